// file: bench/udr_dma_ready_sva.sv
// udr_dma_ready_sva: port-level checks for the dma-ready block
// assumes a bind onto udr_dma_ready, one clock domain
`timescale 1ns/1ps
module udr_dma_ready_sva
(
  input wire logic        clk_sys,
  input wire logic        rst_n,
  input wire logic        hsel,
  input wire logic [11:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hready,
  input wire logic [31:0] hrdata,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic        chipSelect,
  input wire logic        read_strobe_low,
  input wire logic        read_strobe_high,
  input wire logic        strobeRdValid,
  input wire logic        serial_out,
  input wire logic        rx_dma_ready_n,
  input wire logic        tx_dma_ready_n,
  input wire logic        txValid,
  input wire logic [7:0]  txData,
  input wire logic        txReady
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  logic rdPhase_r;
  // ------------------------------------------------------------
  // helper: marks the read data phase
  // ------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      rdPhase_r <= 1'b0;
    else
      rdPhase_r <= hsel && hready && htrans[1] && !hwrite;
  end
  // read to a hole in the map
  sequence s_rd_hole;
    hsel && hready && htrans[1] && !hwrite && (haddr > 12'h010);
  endsequence
  // long enough for a stale synchronised strobe to have died out
  sequence s_no_rd_qual;
    (!chipSelect || (read_strobe_low && !read_strobe_high))[*8];
  endsequence
  a_idle_mark: assert property (serial_out)
    else $error("serial output left marking level");
  a_reset_ready: assert property ($rose(rst_n) |-> rx_dma_ready_n && !tx_dma_ready_n)
    else $error("ready outputs wrong after reset");
  a_tx_hold: assert property (txValid && !txReady |=> txValid && $stable(txData))
    else $error("tx word dropped during stall");
  a_rd_pulse_one: assert property (strobeRdValid |=> !strobeRdValid)
    else $error("strobe read pulse too long");
  a_rd_qualified: assert property (s_no_rd_qual |-> !strobeRdValid)
    else $error("strobe read without select and strobe");
  a_hole_zero: assert property (s_rd_hole |=> hrdata == 32'h0)
    else $error("unmapped read not zero");
  a_idle_rdata: assert property (!rdPhase_r |-> hrdata == 32'h0)
    else $error("read data outside data phase");
  a_bus_okay: assert property (hreadyout && !hresp)
    else $error("bus answer not ready okay");
endmodule

// file: bench/udr_dma_ready_test.sv
// udr_dma_ready_test: self-checking bench for the dma-ready block
// assumes udr_pkg, the serial peer model and the checker are compiled first
`timescale 1ns/1ps
module udr_dma_ready_test
  import udr_pkg::*;
;
  localparam int TMO = 2000;
  logic        clk_sys = 1'b0;
  logic        rst_n = 1'b0;
  logic        hsel = 1'b0;
  logic [11:0] haddr = 12'h000;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        chipSelect = 1'b0;
  logic [3:0]  stb = 4'hA;
  logic [7:0]  strobeWdata = 8'h00;
  logic [7:0]  strobeRdata;
  logic        strobeRdValid;
  logic        serial_in;
  logic        rxClk16;
  logic        serial_out;
  logic        rx_dma_ready_n;
  logic        tx_dma_ready_n;
  logic        txValid;
  logic [7:0]  txData;
  logic        txReady;
  int          err_count = 0;
  int          n_compared = 0;
  int          pulses = 0;
  // ------------------------------------------------------------
  // clock, design and partner
  // ------------------------------------------------------------
  always #20 clk_sys = ~clk_sys;
  udr_dma_ready #(.FIFO_DEPTH(16), .TIMEOUT_CYCLES(TMO)) u_udr_dma_ready (
    .clk_sys(clk_sys), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(), .chipSelect(chipSelect), .write_strobe_low(stb[3]),
    .write_strobe_high(stb[2]), .read_strobe_low(stb[1]), .read_strobe_high(stb[0]),
    .strobeWdata(strobeWdata), .strobeRdata(strobeRdata), .strobeRdValid(strobeRdValid),
    .serial_in(serial_in), .rxClk16(rxClk16), .serial_out(serial_out), .rx_dma_ready_n(rx_dma_ready_n),
    .tx_dma_ready_n(tx_dma_ready_n), .txValid(txValid), .txData(txData), .txReady(txReady));
  udr_serial_peer u_udr_serial_peer (.clk_sys(clk_sys), .rxClk16(rxClk16), .serial_in(serial_in),
    .txValid(txValid), .txData(txData), .txReady(txReady));
  // counts strobe read pulses, sampled where settled
  always @(negedge clk_sys)
    if (strobeRdValid === 1'b1)
      pulses++;
  // ------------------------------------------------------------
  // shared tasks
  // ------------------------------------------------------------
  task automatic stop_test;
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      err_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // single transfer; values are read at the negedge before the taking edge
  task automatic ahb(input logic w, input logic [11:0] a, input logic [31:0] wd, output logic [31:0] rd);
    int n;
    n = 0;
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= w;
    do @(negedge clk_sys); while (hreadyout !== 1'b1 && ++n < 50);
    @(posedge clk_sys);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(negedge clk_sys); while (hreadyout !== 1'b1 && ++n < 100);
    rd = hrdata;
    @(posedge clk_sys);
    chk(n < 50, 1'b1);
    if (n >= 50)
      stop_test;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] x;
    ahb(1'b1, a, d, x);
  endtask
  task automatic rdc(input logic [11:0] a, input logic [31:0] exp, input logic [31:0] m);
    logic [31:0] x;
    ahb(1'b0, a, 32'h0, x);
    chk(x & m, exp);
  endtask
  // waits for a ready output to reach a level; a limit of 1 checks it now
  task automatic wait_lvl(input logic tx, input logic v, input int lim);
    int n;
    n = 0;
    do @(negedge clk_sys); while ((tx ? tx_dma_ready_n : rx_dma_ready_n) !== v && ++n < lim);
    @(posedge clk_sys);
    chk(n < lim, 1'b1);
    if (n >= lim)
      stop_test;
  endtask
  // holds select and strobes past the synchroniser, then idles them
  task automatic stb_op(input logic cs, input logic [3:0] s, input logic [7:0] d);
    chipSelect <= cs;
    stb <= s;
    strobeWdata <= d;
    repeat (6) @(posedge clk_sys);
    chipSelect <= 1'b0;
    stb <= 4'hA;  // unused strobes sit inactive
    repeat (6) @(posedge clk_sys);
  endtask
  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic t_regs;
    rdc(UDR_FIFO_CTRL_OFS, 32'h0, 32'h9);
    wr(UDR_FIFO_CTRL_OFS, 32'h49);
    rdc(UDR_FIFO_CTRL_OFS, 32'h49, 32'h1F9);
    wr(12'h020, 32'hFF);
    rdc(12'h020, 32'h0, 32'hFFFFFFFF);
  endtask
  // fifo off with mode select set, then fifo on with it clear
  task automatic t_rx0;
    logic [31:0] ctl[2] = '{32'h08, 32'h01};
    for (int i = 0; i < 2; i++)
    begin
      wr(UDR_FIFO_CTRL_OFS, ctl[i]);
      u_udr_serial_peer.send(8'hA0 | ctl[i][7:0]);
      wait_lvl(1'b0, 1'b0, 100);
      rdc(UDR_STATUS_OFS, 32'h4, 32'h1FFF);
      rdc(UDR_RX_DATA_OFS, 32'hA0 | ctl[i], 32'hFF);
      wait_lvl(1'b0, 1'b1, 4);
    end
  endtask
  // trigger of four, then a lone character left to time out
  task automatic t_rx1;
    wr(UDR_FIFO_CTRL_OFS, 32'h49);
    for (int i = 0; i < 4; i++)
    begin
      if (i == 3)
        wait_lvl(1'b0, 1'b1, 1);
      u_udr_serial_peer.send(8'h30 + i[7:0]);
    end
    wait_lvl(1'b0, 1'b0, 100);
    for (int i = 0; i < 4; i++)
    begin
      wait_lvl(1'b0, 1'b0, 1);
      rdc(UDR_RX_DATA_OFS, 32'h30 + i, 32'hFF);
    end
    wait_lvl(1'b0, 1'b1, 4);
    u_udr_serial_peer.send(8'h77);
    wait_lvl(1'b0, 1'b1, 1);
    wait_lvl(1'b0, 1'b0, TMO + 500);
    rdc(UDR_RX_DATA_OFS, 32'h77, 32'hFF);
    wait_lvl(1'b0, 1'b1, 4);
  endtask
  // fill against a stalled sink, let one word out, then drain and compare
  task automatic t_tx;
    logic [31:0] ctl[2] = '{32'h00, 32'h49};
    logic [7:0]  sent[$];
    int          n;
    for (int m = 0; m < 2; m++)
    begin
      wr(UDR_FIFO_CTRL_OFS, ctl[m]);
      u_udr_serial_peer.stall <= 1'b1;
      sent = {};
      u_udr_serial_peer.got = {};
      repeat (4) @(posedge clk_sys);
      n = 0;
      @(negedge clk_sys);
      while (tx_dma_ready_n === 1'b0 && n < 24)
      begin
        @(posedge clk_sys);
        wr(UDR_TX_DATA_OFS, 32'h50 + n);
        sent.push_back(8'h50 + n[7:0]);
        n++;
        repeat (2) @(posedge clk_sys);
        @(negedge clk_sys);
      end
      @(posedge clk_sys);
      chk(n >= (m == 1 ? 16 : 1), 1'b1);
      chk(n < 24, 1'b1);
      u_udr_serial_peer.stall <= 1'b0;
      @(posedge clk_sys);
      u_udr_serial_peer.stall <= 1'b1;
      repeat (6) @(posedge clk_sys);
      wait_lvl(1'b1, m == 1, 1);
      u_udr_serial_peer.stall <= 1'b0;
      n = 0;
      while (u_udr_serial_peer.got.size() < sent.size() && n++ < 200)
        @(posedge clk_sys);
      chk(u_udr_serial_peer.got.size(), sent.size());
      foreach (sent[k])
        chk(u_udr_serial_peer.got[k], sent[k]);
      wait_lvl(1'b1, 1'b0, 4);
    end
  endtask
  // strobe order {write low, write high, read low, read high}
  task automatic t_strobe;
    int n;
    stb_op(1'b1, 4'h2, 8'h3C);
    rdc(UDR_STROBE_OFS, 32'h3C, 32'hFF);
    stb_op(1'b0, 4'h2, 8'hC3);
    rdc(UDR_STROBE_OFS, 32'h3C, 32'hFF);
    stb_op(1'b1, 4'hE, 8'h5A);
    rdc(UDR_STROBE_OFS, 32'h5A, 32'hFF);
    u_udr_serial_peer.send(8'h96);
    n = pulses;
    stb_op(1'b1, 4'hB, 8'h00);
    chk(pulses - n, 1);
    chk(strobeRdata, 8'h96);
    stb_op(1'b0, 4'h8, 8'h00);
    chk(pulses - n, 1);
    stb_op(1'b1, 4'h8, 8'h00);
    chk(pulses - n, 2);
    chk(strobeRdata, 8'h00);
  endtask
  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial
  begin
    repeat (3) @(posedge clk_sys);
    rst_n <= 1'b1;
    wait_lvl(1'b0, 1'b1, 1);
    wait_lvl(1'b1, 1'b0, 1);
    chk(serial_out, 1'b1);
    t_regs;
    t_rx0;
    t_rx1;
    t_tx;
    t_strobe;
    stop_test;
  end
endmodule
bind udr_dma_ready udr_dma_ready_sva u_udr_dma_ready_sva (
  .clk_sys(clk_sys), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
  .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .chipSelect(chipSelect),
  .read_strobe_low(read_strobe_low), .read_strobe_high(read_strobe_high), .strobeRdValid(strobeRdValid),
  .serial_out(serial_out), .rx_dma_ready_n(rx_dma_ready_n), .tx_dma_ready_n(tx_dma_ready_n),
  .txValid(txValid), .txData(txData), .txReady(txReady));

// file: bench/udr_serial_peer.sv
// udr_serial_peer: serial partner, sends receive frames and sinks the tx stream
// assumes 8N1 frames, 16 rxClk16 periods a bit, rxClk16 at a quarter of clk_sys
`timescale 1ns/1ps
module udr_serial_peer
(
  input  wire logic       clk_sys,
  output logic            rxClk16,
  output logic            serial_in,
  input  wire logic       txValid,
  input  wire logic [7:0] txData,
  output logic            txReady
);
  logic       stall = 1'b0;
  logic       half = 1'b0;
  logic [7:0] got[$];
  // line idles at marking level
  initial
  begin
    rxClk16 = 1'b0;
    serial_in = 1'b1;
    txReady = 1'b0;
  end
  // receive clock runs free; each level lasts two cycles so the pin filter can follow it
  always @(posedge clk_sys)
  begin
    half <= ~half;
    if (half)
      rxClk16 <= ~rxClk16;
  end
  // sink answers every cycle unless stalled, so bursts run back to back
  always @(posedge clk_sys)
    txReady <= ~stall;
  // sampled mid-cycle, where handshake values are settled
  always @(negedge clk_sys)
    if (txValid === 1'b1 && txReady === 1'b1)
      got.push_back(txData);
  // one frame, lsb first, 64 system cycles a bit
  task automatic send(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++)
    begin
      serial_in <= f[i];
      repeat (64) @(posedge clk_sys);
    end
  endtask
endmodule

// file: rtl/udr_dma_ready.sv
// udr_dma_ready: dma-ready signalling, strobe qualification and serial output idle level
// assumes an AHB-Lite master, a host strobe port and a serial receiver beside this block
//
// The implementer's own choices: the placing of the registers and the AHB-Lite interface to the registers.
`timescale 1ns/1ps

module udr_dma_ready
  import udr_pkg::*;
#(
  parameter int FIFO_DEPTH     = 16,
  parameter int TIMEOUT_CYCLES = UDR_TIMEOUT_CYCLES
)
(
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  // ahb-lite slave
  input  wire logic        hsel,
  input  wire logic [11:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // host strobe port
  input  wire logic        chipSelect,
  input  wire logic        write_strobe_low,
  input  wire logic        write_strobe_high,
  input  wire logic        read_strobe_low,
  input  wire logic        read_strobe_high,
  input  wire logic [7:0]  strobeWdata,
  output logic      [7:0]  strobeRdata,
  output logic             strobeRdValid,
  // serial side
  input  wire logic        serial_in,
  input  wire logic        rxClk16,
  output logic             serial_out,
  output logic             rx_dma_ready_n,
  output logic             tx_dma_ready_n,
  // transmit stream leaving through the two-entry buffer
  output logic             txValid,
  output logic      [7:0]  txData,
  input  wire logic        txReady
);

  localparam int CW = $clog2(FIFO_DEPTH + 1);

  // ----------------------------------------------------------------
  // pin synchronisers: three flops, change counts when 2nd and 3rd agree
  // ----------------------------------------------------------------
  logic [2:0] wslS_r, wshS_r, rslS_r, rshS_r, csS_r, sinS_r, rckS_r;
  logic       wsl_r, wsh_r, rsl_r, rsh_r, cs_r, sin_r, rck_r, rckPrev_r;

  function automatic logic agreeFilt(input logic [2:0] s, input logic prev);
    agreeFilt = (s[2] == s[1]) ? s[2] : prev;
  endfunction

  // synchroniser chains; stage 0 read only by stage 1
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wslS_r <= 3'h7;
      wshS_r <= 3'h0;
      rslS_r <= 3'h7;
      rshS_r <= 3'h0;
      csS_r  <= 3'h0;
      sinS_r <= 3'h7;
      rckS_r <= 3'h0;
    end
    else
    begin
      wslS_r <= {wslS_r[1:0], write_strobe_low};
      wshS_r <= {wshS_r[1:0], write_strobe_high};
      rslS_r <= {rslS_r[1:0], read_strobe_low};
      rshS_r <= {rshS_r[1:0], read_strobe_high};
      csS_r  <= {csS_r[1:0], chipSelect};
      sinS_r <= {sinS_r[1:0], serial_in};
      rckS_r <= {rckS_r[1:0], rxClk16};
    end
  end

  // filtered levels
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wsl_r     <= 1'b1;
      wsh_r     <= 1'b0;
      rsl_r     <= 1'b1;
      rsh_r     <= 1'b0;
      cs_r      <= 1'b0;
      sin_r     <= 1'b1;
      rck_r     <= 1'b0;
      rckPrev_r <= 1'b0;
    end
    else
    begin
      wsl_r     <= agreeFilt(wslS_r, wsl_r);
      wsh_r     <= agreeFilt(wshS_r, wsh_r);
      rsl_r     <= agreeFilt(rslS_r, rsl_r);
      rsh_r     <= agreeFilt(rshS_r, rsh_r);
      cs_r      <= agreeFilt(csS_r, cs_r);
      sin_r     <= agreeFilt(sinS_r, sin_r);
      rck_r     <= agreeFilt(rckS_r, rck_r);
      rckPrev_r <= rck_r;
    end
  end

  // strobe qualification; the host keeps the spare strobe idle, so an OR is enough
  logic wrActive, rdActive, wrActPrev_r, rdActPrev_r, wrPulse, rdPulse;
  assign wrActive = cs_r && (!wsl_r || wsh_r);
  assign rdActive = cs_r && (!rsl_r || rsh_r);
  assign wrPulse  = wrActive && !wrActPrev_r;
  assign rdPulse  = rdActive && !rdActPrev_r;

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wrActPrev_r <= 1'b0;
      rdActPrev_r <= 1'b0;
    end
    else
    begin
      wrActPrev_r <= wrActive;
      rdActPrev_r <= rdActive;
    end
  end

  // ----------------------------------------------------------------
  // ahb-lite slave: zero wait states, always OKAY
  // ----------------------------------------------------------------
  logic        dpWrite_r, dpRead_r;
  logic [11:0] dpAddr_r;
  logic        addrPhase;
  assign addrPhase = hsel && hready && htrans[1];

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      dpWrite_r <= 1'b0;
      dpRead_r  <= 1'b0;
      dpAddr_r  <= 12'h000;
    end
    else
    begin
      dpWrite_r <= addrPhase && hwrite;
      dpRead_r  <= addrPhase && !hwrite;
      dpAddr_r  <= addrPhase ? haddr : dpAddr_r;
    end
  end

  // ----------------------------------------------------------------
  // control register and the strobe-port copy
  // ----------------------------------------------------------------
  logic [7:0] fifoCtrl_r, strobeReg_r;
  logic [4:0] trigLevel_r;
  logic       fifoOn, modeSel, dmaMode1;
  assign fifoOn   = fifoCtrl_r[UDR_FIFO_ENABLE_POS];
  assign modeSel  = fifoCtrl_r[UDR_DMA_MODE_SEL_POS];
  // mode select only counts with fifo on; otherwise mode 0
  assign dmaMode1 = fifoOn && modeSel;

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      fifoCtrl_r  <= UDR_FIFO_CTRL_RST;
      trigLevel_r <= UDR_TRIG_RST;
    end
    else if (dpWrite_r && dpAddr_r == UDR_FIFO_CTRL_OFS)
    begin
      fifoCtrl_r  <= hwdata[7:0];  // fifo contents are not touched here
      trigLevel_r <= (hwdata[UDR_TRIG_POS +: 5] == 5'h00) ? UDR_TRIG_RST : hwdata[UDR_TRIG_POS +: 5];
    end
  end

  // strobe-port write lands in its own register
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      strobeReg_r <= 8'h00;
    else if (wrPulse)
      strobeReg_r <= strobeWdata;
  end

  // ----------------------------------------------------------------
  // receive side: sampler on the 16x clock edge, then fifo
  // ----------------------------------------------------------------
  logic [7:0] rxMem [FIFO_DEPTH];
  logic [CW-1:0] rxCount_r;
  logic [$clog2(FIFO_DEPTH)-1:0] rxWp_r, rxRp_r;
  logic [3:0] rxTick_r;
  logic [3:0] rxBit_r;
  logic [7:0] rxShift_r;
  logic       rxBusy_r;
  logic       rxEdge, rxPush, rxPopBus, rxPopStb, rxPop;
  assign rxEdge   = rck_r && !rckPrev_r;  // sample only on the 16x clock
  assign rxPopBus = dpRead_r && dpAddr_r == UDR_RX_DATA_OFS;
  assign rxPopStb = rdPulse;
  assign rxPop    = (rxPopBus || rxPopStb) && rxCount_r != '0;
  assign rxPush   = rxEdge && rxBusy_r && rxTick_r == 4'hF && rxBit_r == 4'h8 && sin_r
                    && rxCount_r != CW'(FIFO_DEPTH);

  // bit sampler: start detect, then mid-bit samples every 16 ticks
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rxBusy_r  <= 1'b0;
      rxTick_r  <= 4'h0;
      rxBit_r   <= 4'h0;
      rxShift_r <= 8'h00;
    end
    else if (rxEdge)
    begin
      if (!rxBusy_r)
      begin
        rxBusy_r <= !sin_r;
        rxTick_r <= 4'h8;  // first hit lands mid start bit
        rxBit_r  <= 4'hF;
      end
      else
      begin
        rxTick_r <= rxTick_r + 4'h1;
        if (rxTick_r == 4'hF)
        begin
          rxBit_r <= rxBit_r + 4'h1;
          if (rxBit_r == 4'hF && sin_r)
            rxBusy_r <= 1'b0;  // false start
          else if (rxBit_r < 4'h8)
            rxShift_r <= {sin_r, rxShift_r[7:1]};
          else if (rxBit_r == 4'h8)
            rxBusy_r <= 1'b0;
        end
      end
    end
  end

  // receive fifo; in character mode it holds a single entry
  logic [CW-1:0] rxLimit;
  assign rxLimit = fifoOn ? CW'(FIFO_DEPTH) : CW'(1);

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rxCount_r <= '0;
      rxWp_r    <= '0;
      rxRp_r    <= '0;
    end
    else
    begin
      if (rxPush && rxCount_r < rxLimit)
        rxWp_r <= rxWp_r + 1'b1;
      if (rxPop)
        rxRp_r <= rxRp_r + 1'b1;
      rxCount_r <= rxCount_r + CW'(rxPush && rxCount_r < rxLimit) - CW'(rxPop);
    end
  end

  // receive storage has no reset, so it stays out of the reset process and maps onto plain memory
  always_ff @(posedge clk_sys)
  begin
    if (rxPush && rxCount_r < rxLimit)
      rxMem[rxWp_r] <= rxShift_r;
  end

  // character time-out: data held and nothing moved for the set time
  logic [15:0] toCnt_r;
  logic        timedOut;
  assign timedOut = toCnt_r >= 16'(TIMEOUT_CYCLES);

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      toCnt_r <= UDR_TIMEOUT_RST;
    else if (rxCount_r == '0 || rxPush || rxPop)
      toCnt_r <= UDR_TIMEOUT_RST;
    else if (!timedOut)
      toCnt_r <= toCnt_r + 16'h0001;
  end

  // mode 1 state: armed by any data, set to drain by trigger or time-out, held until drained
  udr_rx_state_type rxState_r;
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      rxState_r <= UDR_RX_IDLE;
    else
    begin
      case (rxState_r)
        UDR_RX_IDLE:
          if (rxCount_r != '0)
            rxState_r <= UDR_RX_ARMED;
        UDR_RX_ARMED:
          if (rxCount_r == '0)
            rxState_r <= UDR_RX_IDLE;
          else if (rxCount_r >= CW'(trigLevel_r) || timedOut)
            rxState_r <= UDR_RX_DRAIN;
        UDR_RX_DRAIN:
          if (rxCount_r == '0)
            rxState_r <= UDR_RX_IDLE;
        default:
          rxState_r <= UDR_RX_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // transmit side: fifo feeding a two-entry output buffer
  // ----------------------------------------------------------------
  logic [7:0] txMem [FIFO_DEPTH];
  logic [CW-1:0] txCount_r;
  logic [$clog2(FIFO_DEPTH)-1:0] txWp_r, txRp_r;
  logic [CW-1:0] txLimit;
  logic       txPushReq, txPush, txPop;
  udr_word_type buf0_r, buf1_r;
  assign txLimit   = fifoOn ? CW'(FIFO_DEPTH) : CW'(1);
  assign txPushReq = (dpWrite_r && dpAddr_r == UDR_TX_DATA_OFS) || wrPulse;
  assign txPush    = txPushReq && txCount_r < txLimit;  // a write into a full side is dropped
  assign txPop     = txCount_r != '0 && !buf1_r.valid;

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      txCount_r <= '0;
      txWp_r    <= '0;
      txRp_r    <= '0;
    end
    else
    begin
      if (txPush)
        txWp_r <= txWp_r + 1'b1;
      if (txPop)
        txRp_r <= txRp_r + 1'b1;
      txCount_r <= txCount_r + CW'(txPush) - CW'(txPop);
    end
  end

  // transmit storage, no reset for the same reason as the receive side
  always_ff @(posedge clk_sys)
  begin
    if (txPush)
      txMem[txWp_r] <= dpWrite_r ? hwdata[7:0] : strobeWdata;
  end

  // two-entry skid buffer; a stalled receiver backs up into the fifo
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      buf0_r <= '0;
      buf1_r <= '0;
    end
    else
    begin
      if (!buf0_r.valid || txReady)
      begin
        if (buf1_r.valid)
        begin
          buf0_r <= buf1_r;
          buf1_r <= txPop ? udr_word_type'({1'b1, txMem[txRp_r]}) : '0;
        end
        else
          buf0_r <= txPop ? udr_word_type'({1'b1, txMem[txRp_r]}) : '0;
      end
      else if (txPop)
        buf1_r <= udr_word_type'({1'b1, txMem[txRp_r]});
    end
  end

  assign txValid = buf0_r.valid;
  assign txData  = buf0_r.data;

  // ----------------------------------------------------------------
  // ready outputs and serial idle level
  // ----------------------------------------------------------------
  udr_ready_type ready_r, ready_nxt;
  always_comb
  begin
    // mode 0: low while any word waits, cleared as soon as the last word leaves
    ready_nxt.rxReadyN = (rxCount_r == '0);
    if (dmaMode1)
      ready_nxt.rxReadyN = (rxState_r != UDR_RX_DRAIN) || rxCount_r == '0;
    // mode 0: low while any room; mode 1: low only when empty, held until full
    ready_nxt.txReadyN = (txCount_r >= txLimit);
    if (dmaMode1)
      ready_nxt.txReadyN = ready_r.txReadyN ? (txCount_r != '0) : (txCount_r >= txLimit);
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ready_r    <= '{rxReadyN: 1'b1, txReadyN: 1'b0};
      serial_out <= 1'b1;  // idle marking level
    end
    else
    begin
      ready_r    <= ready_nxt;
      serial_out <= 1'b1;  // framing lives outside; line stays marking
    end
  end

  assign rx_dma_ready_n = ready_r.rxReadyN;
  assign tx_dma_ready_n = ready_r.txReadyN;

  // ----------------------------------------------------------------
  // read data paths
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      strobeRdata   <= 8'h00;
      strobeRdValid <= 1'b0;
    end
    else
    begin
      strobeRdValid <= rdPulse;
      strobeRdata   <= rdPulse ? (rxCount_r != '0 ? rxMem[rxRp_r] : 8'h00) : strobeRdata;
    end
  end

  always_comb
  begin
    hrdata = 32'h0000_0000;
    if (dpRead_r)
    begin
      case (dpAddr_r)
        UDR_FIFO_CTRL_OFS: hrdata = {23'h0, trigLevel_r, fifoCtrl_r[3:0]};
        UDR_STATUS_OFS:    hrdata = {19'h0, txCount_r, 1'b0, rxCount_r, ready_r};
        UDR_RX_DATA_OFS:   hrdata = {24'h0, (rxCount_r != '0) ? rxMem[rxRp_r] : 8'h00};
        UDR_STROBE_OFS:    hrdata = {24'h0, strobeReg_r};
        default:           hrdata = 32'h0000_0000;
      endcase
    end
  end

  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

endmodule

// file: rtl/udr_pkg.sv
// udr_pkg: constants, register map and carrier types for the uart dma-ready block
// assumes a single 25 MHz system clock and an AHB-Lite master with 32-bit data
package udr_pkg;

  // ----------------------------------------------------------------
  // register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [11:0] UDR_FIFO_CTRL_OFS = 12'h000;  // fifo_control_register
  localparam logic [11:0] UDR_STATUS_OFS    = 12'h004;  // ready outputs, fill levels
  localparam logic [11:0] UDR_TX_DATA_OFS   = 12'h008;  // write: transmit word
  localparam logic [11:0] UDR_RX_DATA_OFS   = 12'h00C;  // read: receive word
  localparam logic [11:0] UDR_STROBE_OFS    = 12'h010;  // last strobe-port write value

  // ----------------------------------------------------------------
  // field positions and reset values
  // ----------------------------------------------------------------
  localparam int          UDR_FIFO_ENABLE_POS   = 0;    // fifo_enable_bit
  localparam int          UDR_DMA_MODE_SEL_POS  = 3;    // dma_mode_select_bit
  localparam int          UDR_TRIG_POS          = 4;    // receive trigger level field
  localparam logic [7:0]  UDR_FIFO_CTRL_RST     = 8'h00;
  localparam logic [4:0]  UDR_TRIG_RST          = 5'h01;
  localparam logic [15:0] UDR_TIMEOUT_RST       = 16'h0000;
  localparam logic [1:0]  UDR_SYNC_RST          = 2'h3;

  // character time-out (time and derived cycles)
  localparam int UDR_CLK_MHZ        = 25;
  localparam int UDR_TIMEOUT_US     = 40;
  localparam int UDR_TIMEOUT_CYCLES = UDR_TIMEOUT_US * UDR_CLK_MHZ;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef struct packed
  {
    logic       valid;
    logic [7:0] data;
  } udr_word_type;

  typedef struct packed
  {
    logic rxReadyN;
    logic txReadyN;
  } udr_ready_type;

  typedef enum logic [2:0]
  {
    UDR_RX_IDLE  = 3'b001,
    UDR_RX_ARMED = 3'b010,
    UDR_RX_DRAIN = 3'b100
  } udr_rx_state_type;

endpackage
